/* common/rcc_params.svh */
// offsets, field positions, reset values and timing counts of the system clock control
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define RCC_MODE_REG_IDX     12'h0ca
`define RCC_STATUS_REG_IDX   12'h0cb
`define RCC_WORD_BYTES       12'h004
`define RCC_MODE_REG_ADDR    (`RCC_MODE_REG_IDX * `RCC_WORD_BYTES)
`define RCC_STATUS_REG_ADDR  (`RCC_STATUS_REG_IDX * `RCC_WORD_BYTES)

// mode register field positions
`define RCC_FAST_STOP_BIT    1
`define RCC_SLOW_SEL_BIT     2
`define RCC_SLEEP_BIT        3
`define RCC_GREEN_BIT        4

// mode register reset values
`define RCC_FAST_STOP_RST    1'b0
`define RCC_SLOW_SEL_RST     1'b0
`define RCC_SLEEP_RST        1'b0
`define RCC_GREEN_RST        1'b0

// cpu state field encodings {green, sleep}
`define RCC_CPU_NORMAL       2'b00
`define RCC_CPU_SLEEP        2'b01
`define RCC_CPU_GREEN        2'b10

// warm-up lengths in fast oscillator cycles
`define RCC_RESET_WARM_CYC   12'd2048
`define RCC_WAKE_WARM_CYC    12'd32

// slow mode instruction rate divisor
`define RCC_SLOW_DIV         5'd4

// fast oscillator and bus clock rates in kHz, used by the rate accumulator
`define RCC_FAST_OSC_KHZ     16'd16000
`define RCC_HCLK_KHZ         16'd20000

`endif

/* common/rcc_pkg.sv */
// types shared by the system clock control block
package rcc_pkg;

   typedef enum logic [2:0] {
      RCC_WARM_RESET,
      RCC_RUN,
      RCC_SLEEP,
      RCC_GREEN,
      RCC_NOCLK,
      RCC_WARM_WAKE
   } rcc_state_e;

   typedef struct packed {
      logic green_request;
      logic sleep_request;
      logic slow_clock_select;
      logic fast_osc_stop;
   } rcc_mode_s;

   typedef struct packed {
      logic cpu_run;
      logic fast_osc_on;
      logic slow_osc_on;
      logic slow_active;
   } rcc_osc_s;

   typedef struct packed {
      logic slow_rc_clk;
      logic port_wake;
      logic timer_wake;
      logic wdt_enable;
   } rcc_pins_s;

endpackage

/* src/rcc_clock_ctrl.sv */
// dual rc system clock control with an ahb-lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "rcc_params.svh"

// Operation
// - normal mode instruction rate is fast oscillator divided by a build option 1..16
// - slow mode instruction rate is always slow oscillator divided by four
// - fast oscillator is 16 MHz and the only fast source of the divider
// - mode bit 1 stops the fast oscillator; slow oscillator keeps running in slow mode
// - mode bit 2 picks slow oscillator as system clock source
// - mode bits 4:3 give cpu state: normal, sleep, green, reserved
// - slow oscillator stops only in sleep, fast stop in normal mode, or green in slow mode without watchdog
// - slow oscillator feeds watchdog and slow mode clock, chosen by bit 2
// - after any reset wait 2048 fast oscillator cycles before running
// - after sleep wake-up wait 32 fast oscillator cycles before running
// - hardware clears the sleep request or green request on wake-up
// - sleep wake-up always resumes in normal mode
// - green wake-up resumes in the mode that was active on entry
// - fast oscillator stopped in normal mode acts as sleep until a port wake
module rcc_clock_ctrl
   import rcc_pkg::*;
#(
   parameter logic [4:0] FCPU_DIV = 5'd4
) (
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // asynchronous pins
   input  wire rcc_pkg::rcc_pins_s pins,
   // clock results
   output logic                   cpu_tick,
   output rcc_pkg::rcc_osc_s      osc_status
);
   import rcc_pkg::*;

   rcc_pins_s  pins_s;
   rcc_mode_s  mode_q;
   rcc_state_e state_q;
   logic [11:0] warm_cnt_q;
   logic [15:0] fast_acc_q;
   logic        fast_tick_q;
   logic        slow_prev_q;
   logic        slow_tick;
   logic        slow_cut;
   logic        fast_osc_en_q;
   logic        slow_osc_en_q;
   logic        cpu_run_q;
   logic        div_slow_active;
   logic        wake_port_q;
   logic        wake_timer_q;

   // ahb data phase bookkeeping
   logic        dp_write_q;
   logic        dp_mode_q;
   logic        addr_take;
   logic        sel_mode;
   logic        sel_status;
   logic [31:0] rd_mux;

   // state machine decisions
   logic        sleep_wake;
   logic        green_wake;
   logic        noclk_wake;
   logic        warm_done;
   logic [11:0] warm_lim;

   rcc_sync #(
      .W        ($bits(rcc_pins_s))
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (pins),
      .sync_out (pins_s)
   );

   // bus slave: zero wait state, read data is prepared in the address phase
   always_comb begin
      addr_take  = hsel && htrans[1] && hready;
      sel_mode   = haddr[11:0] == `RCC_MODE_REG_ADDR;
      sel_status = haddr[11:0] == `RCC_STATUS_REG_ADDR;
      rd_mux     = 32'h0000_0000;
      if (sel_mode) begin
         rd_mux[`RCC_FAST_STOP_BIT] = mode_q.fast_osc_stop;
         rd_mux[`RCC_SLOW_SEL_BIT]  = mode_q.slow_clock_select;
         rd_mux[`RCC_SLEEP_BIT]     = mode_q.sleep_request;
         rd_mux[`RCC_GREEN_BIT]     = mode_q.green_request;
      end else if (sel_status) begin
         rd_mux[2:0] = state_q;
         rd_mux[3]   = cpu_run_q;
         rd_mux[4]   = fast_osc_en_q;
         rd_mux[5]   = slow_osc_en_q;
         rd_mux[6]   = div_slow_active;
         rd_mux[7]   = wake_port_q;
         rd_mux[8]   = wake_timer_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_q <= 1'b0;
         dp_mode_q  <= 1'b0;
         hrdata     <= 32'h0000_0000;
      end else begin
         dp_write_q <= addr_take && hwrite;
         dp_mode_q  <= sel_mode;
         if (addr_take && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // transfers are single words and the answer is always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // oscillator models: fast rate by accumulator, slow rate from its pin

   // 16 MHz ticks are spread over the 20 MHz bus clock; a stopped oscillator gives none
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_acc_q  <= 16'h0000;
         fast_tick_q <= 1'b0;
      end else if (!fast_osc_en_q) begin
         fast_acc_q  <= 16'h0000;
         fast_tick_q <= 1'b0;
      end else if (fast_acc_q + `RCC_FAST_OSC_KHZ >= `RCC_HCLK_KHZ) begin
         fast_acc_q  <= fast_acc_q + `RCC_FAST_OSC_KHZ - `RCC_HCLK_KHZ;
         fast_tick_q <= 1'b1;
      end else begin
         fast_acc_q  <= fast_acc_q + `RCC_FAST_OSC_KHZ;
         fast_tick_q <= 1'b0;
      end
   end

   // edge detector reads the synchronised level only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_prev_q <= 1'b0;
      end else begin
         slow_prev_q <= pins_s.slow_rc_clk;
      end
   end

   always_comb begin
      slow_cut  = (state_q == RCC_GREEN) && mode_q.slow_clock_select && !pins_s.wdt_enable;
      slow_tick = slow_osc_en_q && !slow_cut && pins_s.slow_rc_clk && !slow_prev_q;
   end

   rcc_rate_div #(
      .FCPU_DIV    (FCPU_DIV)
   ) u_div (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .fast_tick   (fast_tick_q),
      .slow_tick   (slow_tick),
      .slow_req    (mode_q.slow_clock_select),
      .run         ((state_q == RCC_RUN) || (state_q == RCC_GREEN)),
      .cpu_tick    (cpu_tick),
      .slow_active (div_slow_active)
   );

   // wake decisions and warm-up counting
   always_comb begin
      sleep_wake = (state_q == RCC_SLEEP) && pins_s.port_wake;
      green_wake = (state_q == RCC_GREEN) && (pins_s.port_wake || pins_s.timer_wake);
      noclk_wake = (state_q == RCC_NOCLK) && pins_s.port_wake;
      warm_lim   = (state_q == RCC_WARM_RESET) ? `RCC_RESET_WARM_CYC : `RCC_WAKE_WARM_CYC;
      warm_done  = fast_tick_q && (warm_cnt_q == warm_lim - 12'd1);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warm_cnt_q <= 12'h000;
      end else if ((state_q != RCC_WARM_RESET) && (state_q != RCC_WARM_WAKE)) begin
         warm_cnt_q <= 12'h000;
      end else if (warm_done) begin
         warm_cnt_q <= 12'h000;
      end else if (fast_tick_q) begin
         warm_cnt_q <= warm_cnt_q + 12'd1;
      end
   end

   // operating state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= RCC_WARM_RESET;
      end else begin
         case (state_q)
            RCC_WARM_RESET: begin
               if (warm_done) begin
                  state_q <= RCC_RUN;
               end
            end
            RCC_WARM_WAKE: begin
               if (warm_done) begin
                  state_q <= RCC_RUN;
               end
            end
            RCC_RUN: begin
               // reserved state code 11 is ignored and execution carries on
               case ({mode_q.green_request, mode_q.sleep_request})
                  `RCC_CPU_SLEEP: begin
                     state_q <= RCC_SLEEP;
                  end
                  `RCC_CPU_GREEN: begin
                     state_q <= RCC_GREEN;
                  end
                  default: begin
                     if (!mode_q.slow_clock_select && mode_q.fast_osc_stop) begin
                        state_q <= RCC_NOCLK;
                     end
                  end
               endcase
            end
            RCC_SLEEP: begin
               if (sleep_wake) begin
                  state_q <= RCC_WARM_WAKE;
               end
            end
            RCC_NOCLK: begin
               if (noclk_wake) begin
                  state_q <= RCC_WARM_WAKE;
               end
            end
            RCC_GREEN: begin
               if (green_wake) begin
                  state_q <= RCC_RUN;
               end
            end
            default: begin
               state_q <= RCC_WARM_RESET;
            end
         endcase
      end
   end

   // mode register: software writes, hardware clears on wake-up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q.fast_osc_stop     <= `RCC_FAST_STOP_RST;
         mode_q.slow_clock_select <= `RCC_SLOW_SEL_RST;
         mode_q.sleep_request     <= `RCC_SLEEP_RST;
         mode_q.green_request     <= `RCC_GREEN_RST;
      end else begin
         if (dp_write_q && dp_mode_q) begin
            mode_q.fast_osc_stop     <= hwdata[`RCC_FAST_STOP_BIT];
            mode_q.slow_clock_select <= hwdata[`RCC_SLOW_SEL_BIT];
            mode_q.sleep_request     <= hwdata[`RCC_SLEEP_BIT];
            mode_q.green_request     <= hwdata[`RCC_GREEN_BIT];
         end
         // wake-up clears come last so they override a write in the same cycle
         if (sleep_wake) begin
            mode_q.sleep_request     <= 1'b0;
            mode_q.slow_clock_select <= 1'b0;
            mode_q.fast_osc_stop     <= 1'b0;
         end
         if (green_wake) begin
            mode_q.green_request <= 1'b0;
         end
         if (noclk_wake) begin
            mode_q.fast_osc_stop <= 1'b0;
         end
      end
   end

   // last wake cause, kept for software after it resumes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_port_q  <= 1'b0;
         wake_timer_q <= 1'b0;
      end else if (sleep_wake || noclk_wake || green_wake) begin
         wake_port_q  <= pins_s.port_wake;
         wake_timer_q <= green_wake && !pins_s.port_wake && pins_s.timer_wake;
      end
   end

   // oscillator enables and execution flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_osc_en_q <= 1'b1;
         slow_osc_en_q <= 1'b1;
         cpu_run_q     <= 1'b0;
      end else begin
         case (state_q)
            RCC_WARM_RESET,
            RCC_WARM_WAKE: begin
               fast_osc_en_q <= 1'b1;
               slow_osc_en_q <= 1'b1;
            end
            RCC_RUN: begin
               // fast oscillator stays up until the divider has left it, else the switch never completes
               fast_osc_en_q <= !mode_q.fast_osc_stop || !div_slow_active;
               slow_osc_en_q <= 1'b1;
            end
            RCC_GREEN: begin
               fast_osc_en_q <= !mode_q.fast_osc_stop || !div_slow_active;
               // in slow mode without a watchdog nothing needs the slow oscillator
               slow_osc_en_q <= !slow_cut;
            end
            RCC_SLEEP,
            RCC_NOCLK: begin
               fast_osc_en_q <= 1'b0;
               slow_osc_en_q <= 1'b0;
            end
            default: begin
               fast_osc_en_q <= 1'b1;
               slow_osc_en_q <= 1'b1;
            end
         endcase
         cpu_run_q <= (state_q == RCC_RUN);
      end
   end

   always_comb begin
      osc_status.cpu_run     = cpu_run_q;
      osc_status.fast_osc_on = fast_osc_en_q;
      osc_status.slow_osc_on = slow_osc_en_q;
      osc_status.slow_active = div_slow_active;
   end

endmodule

/* src/rcc_rate_div.sv */
// instruction rate divider with a source switch taken only at a period boundary or while stopped
`include "rcc_params.svh"
module rcc_rate_div #(
   parameter logic [4:0] FCPU_DIV = 5'd4
) (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // sources
   input  wire logic fast_tick,
   input  wire logic slow_tick,
   input  wire logic slow_req,
   input  wire logic run,
   // result
   output logic      cpu_tick,
   output logic      slow_active
);

   logic [4:0] cnt_q;
   logic       src_tick;
   logic [4:0] lim;

   always_comb begin
      src_tick = slow_active ? slow_tick : fast_tick;
      lim      = slow_active ? (`RCC_SLOW_DIV - 5'd1) : (FCPU_DIV - 5'd1);
   end

   // while running, the source only changes once a whole output period is done, so no short period appears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q       <= 5'h00;
         cpu_tick    <= 1'b0;
         slow_active <= 1'b0;
      end else if (!run) begin
         cnt_q       <= 5'h00;
         cpu_tick    <= 1'b0;
         slow_active <= slow_req;
      end else if (src_tick) begin
         if (cnt_q >= lim) begin
            cnt_q       <= 5'h00;
            cpu_tick    <= 1'b1;
            slow_active <= slow_req;
         end else begin
            cnt_q    <= cnt_q + 5'd1;
            cpu_tick <= 1'b0;
         end
      end else begin
         cpu_tick <= 1'b0;
      end
   end

endmodule

/* src/rcc_sync.sv */
// two-stage synchroniser for a group of asynchronous levels
module rcc_sync #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* testbench/rcc_clock_ctrl_chk.sv */
// port-level assertion checker for the system clock control block
module rcc_clock_ctrl_chk
   import rcc_pkg::*;
(
   // clock and reset
   input wire logic               hclk,
   input wire logic               hresetn,
   // bus
   input wire logic               hsel,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire logic [31:0]        hrdata,
   // clock results
   input wire logic               cpu_tick,
   input wire rcc_pkg::rcc_osc_s  osc_status
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic [11:0] warm_q;
   logic        ran_q;

   // saturates so a long run never wraps into a false warm-up figure
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         warm_q <= 12'h000;
      else if (warm_q != 12'hfff)
         warm_q <= warm_q + 12'h001;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ran_q <= 1'b0;
      else if (osc_status.cpu_run)
         ran_q <= 1'b1;
   end

   sequence s_warm_wait;
      ##30 !osc_status.cpu_run ##[1:14] osc_status.cpu_run;
   endsequence

   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   property p_rdata_hold;
      !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
   endproperty
   property p_tick_fast;
      cpu_tick && !osc_status.slow_active |=> !cpu_tick [*4];
   endproperty
   property p_tick_slow;
      cpu_tick && osc_status.slow_active |=> !cpu_tick [*8];
   endproperty
   property p_slow_off;
      !osc_status.slow_osc_on |-> !osc_status.cpu_run && !cpu_tick;
   endproperty
   property p_noclk;
      !osc_status.fast_osc_on && !osc_status.slow_active |-> !cpu_tick;
   endproperty
   property p_reset_warm;
      $rose(osc_status.cpu_run) && !ran_q |-> warm_q >= 12'd2550 && warm_q <= 12'd2570;
   endproperty
   property p_wake_warm;
      $rose(osc_status.fast_osc_on) && !osc_status.cpu_run && ran_q |-> s_warm_wait;
   endproperty

   a_bus_okay:   assert property (p_bus_okay) else $error("bus not ready or not okay");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
   a_tick_fast:  assert property (p_tick_fast) else $error("fast instruction ticks too close");
   a_tick_slow:  assert property (p_tick_slow) else $error("slow instruction ticks too close");
   a_slow_off:   assert property (p_slow_off) else $error("slow oscillator off while running");
   a_noclk:      assert property (p_noclk) else $error("tick without any clock source");
   a_reset_warm: assert property (p_reset_warm) else $error("reset warm-up length wrong");
   a_wake_warm:  assert property (p_wake_warm) else $error("wake warm-up length wrong");
endmodule

/* testbench/tb.sv */
// self-checking bench for the system clock control block
`include "rcc_params.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rcc_pkg::*;

   localparam logic [31:0] MODE = {20'h0, `RCC_MODE_REG_ADDR};
   localparam logic [31:0] STAT = {20'h0, `RCC_STATUS_REG_ADDR};

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic        cpu_tick;
   logic [1:0]  htrans;
   logic [1:0]  sdiv;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   rcc_pins_s   pins;
   rcc_osc_s    osc_status;
   int          n_fail;
   int          compares;
   int          n;

   rcc_clock_ctrl #(.FCPU_DIV(5'd4)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pins, .cpu_tick,
      .osc_status);

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // slow oscillator: period of 8 bus clocks, frozen while its enable is off
   always @(posedge hclk) begin
      sdiv <= sdiv + 2'h1;
      if (sdiv == 2'h3 && osc_status.slow_osc_on === 1'b1)
         pins.slow_rc_clk <= ~pins.slow_rc_clk;
   end

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wait_run(output int c);
      c = 0;
      while (osc_status.cpu_run !== 1'b1 && c < 4000) begin
         @(posedge hclk);
         c++;
      end
   endtask

   task automatic ticks(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge hclk);
         if (cpu_tick === 1'b1)
            c++;
      end
   endtask

   task automatic pulse(input logic port);
      @(posedge hclk);
      if (port)
         pins.port_wake <= 1'b1;
      else
         pins.timer_wake <= 1'b1;
      repeat (4) @(posedge hclk);
      pins.port_wake <= 1'b0;
      pins.timer_wake <= 1'b0;
   endtask

   task automatic close_out;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = '0;
      pins = '0;
      sdiv = 2'h0;
      n_fail = 0;
      compares = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, MODE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, STAT, 32'h0);
      chk(rd & 32'hf, 32'h0);
      wait_run(n);
      chk_rng(n, 2540, 2570);
      ticks(100, n);
      chk_rng(n, 20, 20);
      chk({28'h0, osc_status}, 32'he);
      bus(1'b1, MODE, 32'hffffffe1);
      bus(1'b0, MODE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, MODE, 32'h18);
      repeat (5) @(posedge hclk);
      chk({31'h0, osc_status.cpu_run}, 32'h1);
      bus(1'b0, 32'h400, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, MODE, 32'h06);
      bus(1'b0, MODE, 32'h0);
      chk(rd, 32'h06);
      repeat (80) @(posedge hclk);
      chk({30'h0, osc_status.fast_osc_on, osc_status.slow_active}, 32'h1);
      ticks(320, n);
      chk_rng(n, 9, 11);
      // green from slow mode, with and without the watchdog
      for (int w = 1; w >= 0; w--) begin
         pins.wdt_enable <= w[0];
         bus(1'b1, MODE, 32'h16);
         repeat (10) @(posedge hclk);
         chk({31'h0, osc_status.slow_osc_on}, {31'h0, w[0]});
         pulse(1'b0);
         wait_run(n);
         chk_rng(n, 0, 3);
         bus(1'b0, MODE, 32'h0);
         chk(rd, 32'h06);
         bus(1'b0, STAT, 32'h0);
         chk(rd & 32'h180, 32'h100);
      end
      bus(1'b1, MODE, 32'h0e);
      repeat (5) @(posedge hclk);
      chk({30'h0, osc_status.fast_osc_on, osc_status.slow_osc_on}, 32'h0);
      pulse(1'b0);
      repeat (10) @(posedge hclk);
      chk({31'h0, osc_status.cpu_run}, 32'h0);
      pulse(1'b1);
      wait_run(n);
      chk_rng(n, 36, 44);
      bus(1'b0, MODE, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, osc_status.slow_active}, 32'h0);
      bus(1'b1, MODE, 32'h02);
      repeat (5) @(posedge hclk);
      chk({30'h0, osc_status.cpu_run, osc_status.fast_osc_on}, 32'h0);
      pulse(1'b1);
      wait_run(n);
      chk_rng(n, 36, 44);
      bus(1'b1, MODE, 32'h10);
      repeat (5) @(posedge hclk);
      chk({30'h0, osc_status.cpu_run, osc_status.fast_osc_on}, 32'h1);
      pulse(1'b1);
      wait_run(n);
      chk_rng(n, 0, 3);
      bus(1'b0, MODE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, STAT, 32'h0);
      chk(rd & 32'h180, 32'h080);
      close_out();
   end
endmodule

bind rcc_clock_ctrl rcc_clock_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .cpu_tick, .osc_status);
